// *** core/comparator_control.sv ***
// Comparator pair control: APB registers, enable/soft reset synchroniser, sample divider, output filters
//
// Operation
// - Filter adds N-1 sample cycles before validity
// - Continuous mode valid after N samples collected
// - Then new output every tick from N samples
// - Single-shot completes at the Nth sample
// - Low-power mux bit applied without synchronisation
// - Keep-running bit keeps pair alive in sleep
// - Enable bit reads back at once, acts later
// - Enable write sets busy until applied
// - Comparator runs only with both enables set
// - Writing soft reset one resets and disables
// - Soft reset write discards other written fields
// - Reset completion clears trigger and busy together
// - Output change needs N/2+1 of N agreeing
// - Filter none, three or five, per comparator
//
// Our own choice: the APB register port.
`include "comparator_map.svh"

module comparator_control
    import comparator_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power manager
    input wire logic standby_sleep,
    // Analog comparator pair
    input wire logic [1:0] comp_raw,
    output logic [1:0] comp_enable,
    output logic low_power_input_mux,
    // Filtered results
    output logic [1:0] filtered_out,
    output logic [1:0] result_valid,
    output logic [1:0] comp_done
);
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] compctrl_reg [2];
    logic [7:0] compctrl_next [2];
    logic [7:0] clkdiv_reg, clkdiv_next;
    logic [7:0] div_cnt_reg, div_cnt_next;
    logic enable_active_reg, enable_active_next;
    logic sync_busy_reg, sync_busy_next;
    sync_state_e sync_state_reg, sync_state_next;
    logic [1:0] sync_cnt_reg, sync_cnt_next;
    logic [1:0] start_reg, start_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;
    logic setup, access, mapped, wr_ctrl, wr_soft_reset_trigger;
    logic tick, sleep_off;
    logic [1:0] comp_run, comp_sample, f_result, f_valid, f_done;

    // Bus phase decode
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign mapped = (paddr == `CMP_CTRL_OFFSET) || (paddr == `CMP_STATUS_OFFSET) ||
                    (paddr == `CMP_COMPCTRL0_OFFSET) || (paddr == `CMP_COMPCTRL1_OFFSET) ||
                    (paddr == `CMP_START_OFFSET) || (paddr == `CMP_CLKDIV_OFFSET);
    assign wr_ctrl = access && pwrite && (paddr == `CMP_CTRL_OFFSET);
    assign wr_soft_reset_trigger = wr_ctrl && pwdata[`CTRL_SOFT_RESET_BIT];

    // Comparator sample clock enable
    // Greater-or-equal, so lowering the divider wraps at once instead of after 256 counts
    assign tick = (div_cnt_reg >= clkdiv_reg);
    always_comb begin
        div_cnt_next = tick ? 8'h00 : div_cnt_reg + 8'h01;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= 8'h00;
        end else begin
            div_cnt_reg <= div_cnt_next;
        end
    end

    // Register writes, synchroniser and soft reset
    always_comb begin
        ctrl_next = ctrl_reg;
        compctrl_next = compctrl_reg;
        clkdiv_next = clkdiv_reg;
        enable_active_next = enable_active_reg;
        sync_busy_next = sync_busy_reg;
        sync_state_next = sync_state_reg;
        sync_cnt_next = sync_cnt_reg;
        start_next = 2'h0;
        case (sync_state_reg)
            SYNC_WAIT: begin
                if (tick) begin
                    sync_cnt_next = sync_cnt_reg + 2'h1;
                    if (sync_cnt_reg + 2'h1 == `SYNC_TICKS) begin
                        sync_state_next = SYNC_APPLY;
                    end
                end
            end
            SYNC_APPLY: begin
                sync_state_next = SYNC_IDLE;
                sync_busy_next = 1'b0;
                if (ctrl_reg[`CTRL_SOFT_RESET_BIT]) begin
                    ctrl_next = `CTRL_RESET;
                    compctrl_next[0] = `COMPCTRL_RESET;
                    compctrl_next[1] = `COMPCTRL_RESET;
                    clkdiv_next = `CLKDIV_RESET;
                    enable_active_next = 1'b0;
                end else begin
                    enable_active_next = ctrl_reg[`CTRL_ENABLE_BIT];
                end
            end
            default: begin
                sync_cnt_next = 2'h0;
            end
        endcase
        if (wr_ctrl) begin
            if (wr_soft_reset_trigger) begin
                ctrl_next = ctrl_reg | 8'h01;
            end else begin
                ctrl_next = (pwdata[7:0] & `CTRL_WRITE_MASK) | (ctrl_reg & 8'h01);
            end
            sync_busy_next = 1'b1;
            sync_state_next = SYNC_WAIT;
            sync_cnt_next = 2'h0;
        end
        if (access && pwrite && !ctrl_reg[`CTRL_SOFT_RESET_BIT]) begin
            if (paddr == `CMP_COMPCTRL0_OFFSET) begin
                compctrl_next[0] = pwdata[7:0] & `COMPCTRL_WRITE_MASK;
            end
            if (paddr == `CMP_COMPCTRL1_OFFSET) begin
                compctrl_next[1] = pwdata[7:0] & `COMPCTRL_WRITE_MASK;
            end
            if (paddr == `CMP_START_OFFSET) begin
                start_next = pwdata[1:0];
            end
            if (paddr == `CMP_CLKDIV_OFFSET) begin
                clkdiv_next = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `CTRL_RESET;
            compctrl_reg[0] <= `COMPCTRL_RESET;
            compctrl_reg[1] <= `COMPCTRL_RESET;
            clkdiv_reg <= `CLKDIV_RESET;
            enable_active_reg <= 1'b0;
            sync_busy_reg <= 1'b0;
            sync_state_reg <= SYNC_IDLE;
            sync_cnt_reg <= 2'h0;
            start_reg <= 2'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            compctrl_reg <= compctrl_next;
            clkdiv_reg <= clkdiv_next;
            enable_active_reg <= enable_active_next;
            sync_busy_reg <= sync_busy_next;
            sync_state_reg <= sync_state_next;
            sync_cnt_reg <= sync_cnt_next;
            start_reg <= start_next;
        end
    end

    // Read data and error captured in the setup phase
    always_comb begin
        prdata_next = prdata_reg;
        pslverr_next = pslverr_reg;
        if (setup) begin
            pslverr_next = !mapped;
            case (paddr)
                `CMP_CTRL_OFFSET: prdata_next = {24'h00_0000, ctrl_reg};
                `CMP_STATUS_OFFSET: prdata_next = {24'h00_0000, sync_busy_reg, 3'h0, f_valid, f_result};
                `CMP_COMPCTRL0_OFFSET: prdata_next = {24'h00_0000, compctrl_reg[0]};
                `CMP_COMPCTRL1_OFFSET: prdata_next = {24'h00_0000, compctrl_reg[1]};
                `CMP_CLKDIV_OFFSET: prdata_next = {24'h00_0000, clkdiv_reg};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg && access;
    assign pready = 1'b1;

    // Comparator gating and unsynchronised controls
    assign sleep_off = standby_sleep && !ctrl_reg[`CTRL_KEEP_RUNNING_BIT];
    assign low_power_input_mux = ctrl_reg[`CTRL_LOW_POWER_MUX_BIT];
    assign comp_enable = comp_run;

    input_sync #(.WIDTH(2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(comp_raw),
        .sync_out(comp_sample)
    );

    // One filter per comparator
    for (genvar i = 0; i < 2; i++) begin : g_comp
        filter_if fif();
        assign comp_run[i] = enable_active_reg && compctrl_reg[i][`COMPCTRL_ENABLE_BIT] && !sleep_off;
        assign fif.tick = tick;
        assign fif.run = comp_run[i];
        assign fif.single = compctrl_reg[i][`COMPCTRL_SINGLE_BIT];
        assign fif.start = start_reg[i];
        assign fif.filter_length = filter_length_e'(compctrl_reg[i][`COMPCTRL_FILTER_LENGTH_LSB +: 2]);
        assign fif.sample = comp_sample[i];
        assign f_result[i] = fif.result;
        assign f_valid[i] = fif.valid;
        assign f_done[i] = fif.done;
        majority_filter u_filter (
            .pclk(pclk),
            .presetn(presetn),
            .fif(fif)
        );
    end

    assign filtered_out = f_result;
    assign result_valid = f_valid;
    assign comp_done = f_done;

    // Checks
    a_mux_immediate: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl && !wr_soft_reset_trigger |=> low_power_input_mux == $past(pwdata[7]))
        else $error("low-power mux not applied at once");
    a_sleep_gating: assert property (@(posedge pclk) disable iff (!presetn)
        standby_sleep && !ctrl_reg[2] |-> comp_enable == 2'h0)
        else $error("comparator runs in sleep without keep-running");
    a_enable_readback: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl && !wr_soft_reset_trigger |=> ctrl_reg[1] == $past(pwdata[1]))
        else $error("enable bit does not read back at once");
    a_busy_set: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> sync_busy_reg)
        else $error("busy not set on control write");
    a_busy_bounded: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sync_busy_reg) |-> ##[1:800] !sync_busy_reg || wr_ctrl)
        else $error("busy never clears");
    a_enable_applied: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(sync_busy_reg) && !$past(ctrl_reg[0]) |-> enable_active_reg == ctrl_reg[1])
        else $error("busy cleared before enable applied");
    a_both_enables: assert property (@(posedge pclk) disable iff (!presetn)
        comp_enable[0] |-> enable_active_reg && compctrl_reg[0][0])
        else $error("comparator runs without both enables");
    a_both_enables1: assert property (@(posedge pclk) disable iff (!presetn)
        comp_enable[1] |-> enable_active_reg && compctrl_reg[1][0])
        else $error("second comparator runs without both enables");
    a_soft_reset_trigger_zero_noop: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl && !wr_soft_reset_trigger |=> ctrl_reg[0] == $past(ctrl_reg[0]))
        else $error("writing zero to soft reset changed it");
    a_soft_reset_trigger_discard: assert property (@(posedge pclk) disable iff (!presetn)
        wr_soft_reset_trigger |=> ctrl_reg[7:1] == $past(ctrl_reg[7:1]))
        else $error("soft reset write changed other fields");
    a_soft_reset_trigger_done: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(ctrl_reg[0]) |-> !sync_busy_reg && !enable_active_reg && ctrl_reg == 8'h00)
        else $error("soft reset completion wrong");
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 ctrl_reg[6:3] == 4'h0)
        else $error("reserved control bits not zero");
    c_enable_done: cover property (@(posedge pclk) disable iff (!presetn) $rose(enable_active_reg));
    c_soft_reset_trigger_done: cover property (@(posedge pclk) disable iff (!presetn) $fell(ctrl_reg[0]));
    c_sleep_kept: cover property (@(posedge pclk) disable iff (!presetn) standby_sleep && comp_enable != 2'h0);
endmodule

// *** core/input_sync.sv ***
// Two-flop synchroniser for asynchronous comparator outputs
module input_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // Two stages, only the second is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule

// *** core/majority_filter.sv ***
// Majority output filter for one comparator, continuous and single-shot
module majority_filter
    import comparator_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Controller side
    filter_if.filt fif
);
    logic [4:0] hist_reg, hist_next;
    logic [2:0] cnt_reg, cnt_next;
    logic result_reg, result_next;
    logic valid_reg, valid_next;
    logic done_reg, done_next;
    logic busy_reg, busy_next;
    logic [2:0] need;
    logic [4:0] shifted;

    // Majority of the last n samples: n/2+1 must agree
    function automatic logic majority(input logic [4:0] h, input logic [2:0] n);
        logic [4:0] mask;
        logic [2:0] pop;
        mask = (n == 3'h5) ? 5'h1F : (n == 3'h3) ? 5'h07 : 5'h01;
        pop = 3'h0;
        for (int i = 0; i < 5; i++) begin
            pop = pop + {2'h0, h[i] & mask[i]};
        end
        return pop >= ((n >> 1) + 3'h1);
    endfunction

    // Samples needed per filter length
    always_comb begin
        case (fif.filter_length)
            FILT_MAJ3: need = 3'h3;
            FILT_MAJ5: need = 3'h5;
            default: need = 3'h1;
        endcase
    end

    assign shifted = {hist_reg[3:0], fif.sample};

    // Next filter state
    always_comb begin
        hist_next = hist_reg;
        cnt_next = cnt_reg;
        result_next = result_reg;
        valid_next = valid_reg;
        done_next = 1'b0;
        busy_next = busy_reg;
        if (!fif.run) begin
            cnt_next = 3'h0;
            valid_next = 1'b0;
            busy_next = 1'b0;
        end else if (fif.single) begin
            if (fif.start && !busy_reg) begin
                busy_next = 1'b1;
                cnt_next = 3'h0;
                valid_next = 1'b0;
            end else if (busy_reg && fif.tick) begin
                hist_next = shifted;
                cnt_next = cnt_reg + 3'h1;
                if (cnt_reg + 3'h1 == need) begin
                    busy_next = 1'b0;
                    done_next = 1'b1;
                    valid_next = 1'b1;
                    result_next = majority(shifted, need);
                end
            end
        end else if (fif.tick) begin
            hist_next = shifted;
            busy_next = 1'b0;
            if (cnt_reg < need) begin
                cnt_next = cnt_reg + 3'h1;
            end
            if (cnt_reg + 3'h1 >= need) begin
                valid_next = 1'b1;
                result_next = majority(shifted, need);
            end
        end
    end

    // Register filter state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_reg <= 5'h00;
            cnt_reg <= 3'h0;
            result_reg <= 1'b0;
            valid_reg <= 1'b0;
            done_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            hist_reg <= hist_next;
            cnt_reg <= cnt_next;
            result_reg <= result_next;
            valid_reg <= valid_next;
            done_reg <= done_next;
            busy_reg <= busy_next;
        end
    end

    assign fif.result = result_reg;
    assign fif.valid = valid_reg;
    assign fif.done = done_reg;

    // Checks
    a_cont_early_invalid: assert property (@(posedge pclk) disable iff (!presetn)
        fif.run && !fif.single && !valid_reg && fif.tick && (cnt_reg + 3'h2 < need) |=> !valid_reg)
        else $error("filter validated before N-1 extra samples");
    a_cont_first_valid: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(valid_reg) && !fif.single |-> cnt_reg == need)
        else $error("first continuous result before N samples");
    a_result_on_tick: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(result_reg) |-> $past(fif.tick))
        else $error("filtered output changed without a sample tick");
    a_single_nth: assert property (@(posedge pclk) disable iff (!presetn)
        done_reg |-> cnt_reg == need && valid_reg)
        else $error("single-shot done before Nth sample");
    a_majority_vote: assert property (@(posedge pclk) disable iff (!presetn)
        $past(fif.tick && fif.run && !fif.single) && $stable(need) && valid_reg
        |-> result_reg == majority(hist_reg, need))
        else $error("filtered output differs from majority vote");
    c_single_done: cover property (@(posedge pclk) disable iff (!presetn) done_reg && need == 3'h5);
    c_cont_maj3: cover property (@(posedge pclk) disable iff (!presetn) $rose(valid_reg) && need == 3'h3);
endmodule

// *** dv/comparator_filter_and_control_test.sv ***
// Self-checking bench of the comparator control block with its analog partner model
`include "comparator_map.svh"

module comparator_filter_and_control_test
    import comparator_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {filter_length_e f; int k; logic hit;} row_s;
    // Filter setting, glitch length in samples, whether the glitch gets through
    row_s rows[5] = '{'{FILT_NONE, 1, 1}, '{FILT_MAJ3, 1, 0}, '{FILT_MAJ3, 2, 1},
                      '{FILT_MAJ5, 2, 0}, '{FILT_MAJ5, 3, 1}};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, standby_sleep = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, low_power_input_mux, err, hit;
    logic [1:0] comp_raw, comp_enable, filtered_out, result_valid, comp_done;
    logic [1:0] level = 2'h0;
    int num_errors = 0, comparisons = 0, lat, lat0;

    comparator_control uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .standby_sleep, .comp_raw, .comp_enable, .low_power_input_mux, .filtered_out,
        .result_valid, .comp_done);
    comparator_pair_model partner (.pclk, .comp_enable, .level, .comp_raw);

    // 50 MHz clock
    always #10 pclk = ~pclk;

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic timeout();
        num_errors++;
        print_verdict();
    endtask

    // One APB transfer: setup, then access held until pready at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) timeout();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_check(string name, logic [11:0] a, logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(name, rd, exp);
    endtask

    // Poll the busy flag until clear before any further control write
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, `CMP_STATUS_OFFSET, 32'h0000_0000);
            n++;
        end while (rd[`STATUS_SYNC_BUSY_BIT] !== 1'b0 && n < 40);
        if (rd[`STATUS_SYNC_BUSY_BIT] !== 1'b0) timeout();
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        timeout();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_check("ctrl reset", `CMP_CTRL_OFFSET, 32'h0000_0000);
        rd_check("clkdiv reset", `CMP_CLKDIV_OFFSET, 32'h0000_0003);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        check("unmapped error", err, 1'b1);
        check("unmapped data", rd, 32'h0000_0000);
        // Reserved bits and the unsynchronised mux bit
        apb(1'b1, `CMP_CTRL_OFFSET, 32'h0000_00F8);
        wait_idle();
        rd_check("ctrl reserved", `CMP_CTRL_OFFSET, 32'h0000_0080);
        check("mux high", low_power_input_mux, 1'b1);
        // Enable goes through the synchroniser
        apb(1'b1, `CMP_COMPCTRL0_OFFSET, 32'h0000_0001);
        apb(1'b1, `CMP_CTRL_OFFSET, 32'h0000_0002);
        apb(1'b0, `CMP_STATUS_OFFSET, 32'h0000_0000);
        check("busy set", rd[`STATUS_SYNC_BUSY_BIT], 1'b1);
        check("enable pending", comp_enable, 2'b00);
        rd_check("enable readback", `CMP_CTRL_OFFSET, 32'h0000_0002);
        check("mux low", low_power_input_mux, 1'b0);
        wait_idle();
        check("one comparator on", comp_enable, 2'b01);
        // Sleep with and without keep-running
        standby_sleep <= 1'b1;
        repeat (2) @(posedge pclk);
        check("off in sleep", comp_enable, 2'b00);
        apb(1'b1, `CMP_CTRL_OFFSET, 32'h0000_0006);
        wait_idle();
        check("kept in sleep", comp_enable, 2'b01);
        standby_sleep <= 1'b0;
        apb(1'b1, `CMP_CLKDIV_OFFSET, 32'h0000_0000);
        level <= 2'b11;
        // Continuous filtering against glitches of several lengths
        foreach (rows[r]) begin
            apb(1'b1, `CMP_COMPCTRL0_OFFSET, {26'h0, rows[r].f, 4'h1});
            repeat (12) @(posedge pclk);
            check("valid", result_valid[0], 1'b1);
            check("steady", filtered_out[0], 1'b1);
            hit = 1'b0;
            level[0] <= 1'b0;
            repeat (rows[r].k) @(posedge pclk);
            level[0] <= 1'b1;
            repeat (14) begin
                @(posedge pclk);
                if (filtered_out[0] === 1'b0) hit = 1'b1;
            end
            check("glitch through", hit, rows[r].hit);
        end
        // Single shot: latency grows by N-1 samples over no filter
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `CMP_COMPCTRL0_OFFSET, {26'h0, 2'(i), 4'h3});
            repeat (4) @(posedge pclk);
            apb(1'b1, `CMP_START_OFFSET, 32'h0000_0001);
            lat = 0;
            do begin
                @(posedge pclk);
                lat++;
            end while (comp_done[0] !== 1'b1 && lat < 40);
            if (comp_done[0] !== 1'b1) timeout();
            if (i == 0) lat0 = lat;
            check("shot latency", lat - lat0, 2 * i);
            check("shot result", filtered_out[0], 1'b1);
            @(posedge pclk);
            check("done pulse", comp_done[0], 1'b0);
        end
        // Soft reset discards the rest of its write, then restores the register reset values and disables
        apb(1'b1, `CMP_CTRL_OFFSET, 32'h0000_0081);
        @(posedge pclk);
        check("mux discarded", low_power_input_mux, 1'b0);
        wait_idle();
        rd_check("ctrl after reset", `CMP_CTRL_OFFSET, 32'h0000_0000);
        rd_check("compctrl after reset", `CMP_COMPCTRL0_OFFSET, 32'h0000_0000);
        rd_check("clkdiv after reset", `CMP_CLKDIV_OFFSET, 32'h0000_0003);
        check("disabled", comp_enable, 2'b00);
        // Second comparator alone, continuous with no filter
        apb(1'b1, `CMP_COMPCTRL1_OFFSET, 32'h0000_0001);
        apb(1'b1, `CMP_CTRL_OFFSET, 32'h0000_0002);
        wait_idle();
        repeat (20) @(posedge pclk);
        check("second on", comp_enable, 2'b10);
        check("second valid", result_valid, 2'b10);
        check("second result", filtered_out[1], 1'b1);
        // Reset in mid-run clears the applied enable and the filters
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check("reset enables", comp_enable, 2'b00);
        check("reset outputs", {filtered_out, result_valid, comp_done}, 6'h00);
        presetn <= 1'b1;
        rd_check("ctrl after pin reset", `CMP_CTRL_OFFSET, 32'h0000_0000);
        print_verdict();
    end
endmodule

// *** dv/comparator_pair_model.sv ***
// Behavioural model of the analog comparator pair behind the control block
module comparator_pair_model (
    // Clock
    input wire logic pclk,
    // Run enables from the block and wanted comparison levels from the bench
    input wire logic [1:0] comp_enable,
    input wire logic [1:0] level,
    // Comparator outputs
    output logic [1:0] comp_raw
);
    timeunit 1ns;
    timeprecision 1ns;

    initial comp_raw = 2'h0;

    // Follow the level while running; toggle when off so no stale value shows
    always @(posedge pclk) begin
        for (int i = 0; i < 2; i++) begin
            comp_raw[i] <= comp_enable[i] ? level[i] : ~comp_raw[i];
        end
    end
endmodule

// *** inc/comparator_map.svh ***
// Register offsets, field positions, reset values and timing counts of the comparator control block
`ifndef COMPARATOR_MAP_SVH
`define COMPARATOR_MAP_SVH

// Register byte offsets
`define CMP_CTRL_OFFSET 12'h000
`define CMP_STATUS_OFFSET 12'h004
`define CMP_COMPCTRL0_OFFSET 12'h008
`define CMP_COMPCTRL1_OFFSET 12'h00C
`define CMP_START_OFFSET 12'h010
`define CMP_CLKDIV_OFFSET 12'h014

// Main control fields
`define CTRL_SOFT_RESET_BIT 0
`define CTRL_ENABLE_BIT 1
`define CTRL_KEEP_RUNNING_BIT 2
`define CTRL_LOW_POWER_MUX_BIT 7
`define CTRL_WRITE_MASK 8'h86
`define CTRL_RESET 8'h00

// Per-comparator control fields
`define COMPCTRL_ENABLE_BIT 0
`define COMPCTRL_SINGLE_BIT 1
`define COMPCTRL_FILTER_LENGTH_LSB 4
`define COMPCTRL_WRITE_MASK 8'h33
`define COMPCTRL_RESET 8'h00

// Status fields
`define STATUS_RESULT_LSB 0
`define STATUS_VALID_LSB 2
`define STATUS_SYNC_BUSY_BIT 7

// Sample clock divider and synchroniser delay
`define CLKDIV_RESET 8'h03
`define SYNC_TICKS 2'h2

`endif

// *** inc/comparator_pkg.sv ***
// Types shared by the comparator control block
package comparator_pkg;

    // Filter length selection
    typedef enum logic [1:0] {
        FILT_NONE = 2'h0,
        FILT_MAJ3 = 2'h1,
        FILT_MAJ5 = 2'h2
    } filter_length_e;

    // Enable / soft reset synchroniser, Gray from idle through wait to apply; apply back to idle changes both bits
    typedef enum logic [1:0] {
        SYNC_IDLE = 2'b00,
        SYNC_WAIT = 2'b01,
        SYNC_APPLY = 2'b11
    } sync_state_e;

endpackage

// *** inc/filter_if.sv ***
// Control and result signals between the controller and one output filter
interface filter_if;
    import comparator_pkg::*;

    logic tick;
    logic run;
    logic single;
    logic start;
    filter_length_e filter_length;
    logic sample;
    logic result;
    logic valid;
    logic done;

    modport ctrl (output tick, run, single, start, filter_length, sample, input result, valid, done);
    modport filt (input tick, run, single, start, filter_length, sample, output result, valid, done);
endinterface
